// File: design/scp_serial_port.sv
// Overview of operation
// - Default form is three-wire: clock, low enable, one two-way data pin.
// - Enable high: both data pin and output pin are released.
// - Three-wire: separate output pin is never driven.
// - Four-wire bit set: read data on output pin, data pin input only.
// - Four-wire: output pin driven only while read bits shift out.
// - Eight-bit header first; its top bit set means read, clear write.
// - Next two header bits give byte count, one to four.
// - Low five header bits give the 32-location register address.
// - Data bits follow the last header bit with no gap.
// - Header bits sampled on rising serial clock after enable falls.
// - Bit-order control resets to zero, most significant bit first.
// - Bit-order control set: header and data taken LSB first.
// - MSB first: header names highest register, address decrements.
// - LSB first: header names lowest register, address increments.
// - Write bytes captured on eight successive rising serial clocks.
// - Bytes continue, address stepping, until header count is done.
// - Three-wire read drives data pin, changing on falling clocks.
// - Four-wire read uses output pin, same timing, data pin undriven.
`timescale 1ns/10ps
`default_nettype none

`include "scp_defs.svh"

module scp_serial_port
  import scp_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
) (
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  input  wire logic              SERIAL_CLK,
  input  wire logic              SERIAL_ENABLE_N,
  input  wire logic              SERIAL_DATA_I,
  output var  logic              SERIAL_DATA_O,
  output var  logic              SERIAL_DATA_OE,
  output var  logic              SERIAL_OUT_PIN_O,
  output var  logic              SERIAL_OUT_PIN_OE,
  output var  logic              FOUR_WIRE,
  output var  logic              LSB_FIRST,
  output var  logic              REG_WR_STROBE,
  output var  logic [ADDR_W-1:0] REG_WR_ADDR,
  output var  logic [DATA_W-1:0] REG_WR_DATA
);

  // =====================================================================
  // Bit order helpers
  function automatic logic [7:0] shift_in(
    input logic [7:0] cur,
    input logic       bit_in,
    input logic       lsb
  );
    if (lsb) begin
      return {bit_in, cur[7:1]};
    end
    return {cur[6:0], bit_in};
  endfunction : shift_in

  function automatic logic first_bit(
    input logic [7:0] src,
    input logic       lsb
  );
    return lsb ? src[0] : src[7];
  endfunction : first_bit

  function automatic logic [7:0] shift_out(
    input logic [7:0] src,
    input logic       lsb
  );
    if (lsb) begin
      return {1'b0, src[7:1]};
    end
    return {src[6:0], 1'b0};
  endfunction : shift_out

  function automatic logic [4:0] next_addr(
    input logic [4:0] cur,
    input logic       lsb
  );
    if (lsb) begin
      return cur + `SCP_ADDR_STEP;
    end
    return cur - `SCP_ADDR_STEP;
  endfunction : next_addr

  function automatic logic [7:0] opt_byte(
    input logic fw,
    input logic lsb
  );
    logic [7:0] b;
    b                     = `SCP_OPT_RESET;
    b[`SCP_OPT_FOUR_WIRE] = fw;
    b[`SCP_OPT_LSB_FIRST] = lsb;
    return b;
  endfunction : opt_byte

  function automatic logic [7:0] load_byte(
    input logic [4:0] addr,
    input logic [7:0] mem,
    input logic       fw,
    input logic       lsb
  );
    // Option bits live in flops, not in the memory
    if (addr == `SCP_OPT_ADDR) begin
      return opt_byte(fw, lsb);
    end
    return mem;
  endfunction : load_byte

  // =====================================================================
  // Pin filter and bit counting helpers
  function automatic logic filt_next(
    input logic [2:0] sync,
    input logic       cur
  );
    // Change accepted once stages two and three agree
    if (sync[1] == sync[2]) begin
      return sync[2];
    end
    return cur;
  endfunction : filt_next

  function automatic logic last_bit(
    input logic [2:0] cnt
  );
    return cnt == `SCP_BIT_LAST;
  endfunction : last_bit

  function automatic logic [2:0] bit_inc(
    input logic [2:0] cnt
  );
    return cnt + `SCP_BIT_STEP;
  endfunction : bit_inc

  // =====================================================================
  // State
  scp_state_t  st_r;
  scp_state_t  st_nxt;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sen_fall;
  logic        byte_done;
  logic [7:0]  hdr_new;
  logic [7:0]  byte_new;
  logic [7:0]  rd_src;
  logic [7:0]  mem_rdata;

  // =====================================================================
  // Register storage
  scp_regfile #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_regfile (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .we     (st_r.wr_stb),
    .waddr  (st_r.wr_addr),
    .wdata  (st_r.wr_data),
    .raddr  (st_r.addr),
    .rdata  (mem_rdata)
  );

  // =====================================================================
  // Next state
  always_comb begin
    st_nxt        = st_r;
    hdr_new       = '0;
    byte_new      = '0;
    rd_src        = '0;
    byte_done     = 1'b0;
    st_nxt.wr_stb = 1'b0;

    // Three-stage sampling, change accepted when last two agree
    st_nxt.sclk_sync = {st_r.sclk_sync[1:0], SERIAL_CLK};
    st_nxt.sen_sync  = {st_r.sen_sync[1:0], SERIAL_ENABLE_N};
    st_nxt.dat_sync  = {st_r.dat_sync[1:0], SERIAL_DATA_I};
    st_nxt.sclk_flt  = filt_next(st_r.sclk_sync, st_r.sclk_flt);
    st_nxt.sen_flt   = filt_next(st_r.sen_sync, st_r.sen_flt);
    st_nxt.dat_flt   = filt_next(st_r.dat_sync, st_r.dat_flt);

    sclk_rise = st_nxt.sclk_flt & ~st_r.sclk_flt;
    sclk_fall = ~st_nxt.sclk_flt & st_r.sclk_flt;
    sen_fall  = ~st_nxt.sen_flt & st_r.sen_flt;

    if (st_nxt.sen_flt) begin
      // Enable high ends any transfer and releases the pins
      st_nxt.phase    = SCP_IDLE;
      st_nxt.drive_on = 1'b0;
    end else if (sen_fall) begin
      st_nxt.phase    = SCP_HEADER;
      st_nxt.bitcnt   = `SCP_BIT_FIRST;
      st_nxt.hdr      = '0;
      st_nxt.drive_on = 1'b0;
    end else begin
      case (st_r.phase)
        SCP_HEADER: begin
          if (sclk_rise) begin
            hdr_new       = shift_in(st_r.hdr, st_nxt.dat_flt,
                                     st_r.lsb_first);
            st_nxt.hdr    = hdr_new;
            st_nxt.bitcnt = bit_inc(st_r.bitcnt);
            if (last_bit(st_r.bitcnt)) begin
              // Count field holds bytes minus one
              st_nxt.bytes_left = hdr_new[`SCP_HDR_CNT_MSB:
                                          `SCP_HDR_CNT_LSB];
              st_nxt.addr       = hdr_new[`SCP_HDR_ADDR_MSB:
                                          `SCP_HDR_ADDR_LSB];
              st_nxt.bitcnt     = `SCP_BIT_FIRST;
              if (hdr_new[`SCP_HDR_RW]) begin
                st_nxt.phase = SCP_RDATA;
              end else begin
                st_nxt.phase = SCP_WDATA;
              end
            end
          end
        end

        SCP_WDATA: begin
          if (sclk_rise) begin
            byte_new      = shift_in(st_r.shreg, st_nxt.dat_flt,
                                     st_r.lsb_first);
            st_nxt.shreg  = byte_new;
            st_nxt.bitcnt = bit_inc(st_r.bitcnt);
            if (last_bit(st_r.bitcnt)) begin
              byte_done      = 1'b1;
              st_nxt.wr_stb  = 1'b1;
              st_nxt.wr_addr = st_r.addr;
              st_nxt.wr_data = byte_new;
              if (st_r.addr == `SCP_OPT_ADDR) begin
                st_nxt.four_wire = byte_new[`SCP_OPT_FOUR_WIRE];
                st_nxt.lsb_first = byte_new[`SCP_OPT_LSB_FIRST];
              end
            end
          end
        end

        SCP_RDATA: begin
          if (sclk_fall) begin
            // New byte at the first falling edge of each byte slot
            if (st_r.bitcnt == `SCP_BIT_FIRST) begin
              rd_src = load_byte(st_r.addr, mem_rdata, st_r.four_wire,
                                 st_r.lsb_first);
            end else begin
              rd_src = st_r.shreg;
            end
            st_nxt.out_bit  = first_bit(rd_src, st_r.lsb_first);
            st_nxt.shreg    = shift_out(rd_src, st_r.lsb_first);
            st_nxt.drive_on = 1'b1;
          end
          if (sclk_rise) begin
            st_nxt.bitcnt = bit_inc(st_r.bitcnt);
            if (last_bit(st_r.bitcnt)) begin
              byte_done = 1'b1;
            end
          end
        end

        SCP_DONE: begin
          st_nxt.drive_on = 1'b0;
        end

        default: begin
          st_nxt.phase    = SCP_IDLE;
          st_nxt.drive_on = 1'b0;
        end
      endcase

      // Step the address and count down bytes
      if (byte_done) begin
        st_nxt.addr = next_addr(st_r.addr, st_r.lsb_first);
        if (st_r.bytes_left == `SCP_CNT_ONE) begin
          st_nxt.phase    = SCP_DONE;
          st_nxt.drive_on = 1'b0;
        end else begin
          st_nxt.bytes_left = st_r.bytes_left - `SCP_CNT_STEP;
        end
      end
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= SCP_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // Pin drivers
  always_comb begin
    SERIAL_DATA_O     = st_r.out_bit;
    SERIAL_OUT_PIN_O  = st_r.out_bit;
    SERIAL_DATA_OE    = st_r.drive_on & ~st_r.sen_flt
                        & ~st_r.four_wire;
    SERIAL_OUT_PIN_OE = st_r.drive_on & ~st_r.sen_flt
                        & st_r.four_wire;
  end

  assign FOUR_WIRE     = st_r.four_wire;
  assign LSB_FIRST     = st_r.lsb_first;
  assign REG_WR_STROBE = st_r.wr_stb;
  assign REG_WR_ADDR   = st_r.wr_addr;
  assign REG_WR_DATA   = st_r.wr_data;

endmodule : scp_serial_port

`default_nettype wire

// File: shared/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// =====================================================================
// Register map
`define SCP_OPT_ADDR         5'h00
`define SCP_OPT_RESET        8'h00
`define SCP_OPT_FOUR_WIRE    7
`define SCP_OPT_LSB_FIRST    6

// =====================================================================
// Header layout
`define SCP_HDR_RW           7
`define SCP_HDR_CNT_MSB      6
`define SCP_HDR_CNT_LSB      5
`define SCP_HDR_ADDR_MSB     4
`define SCP_HDR_ADDR_LSB     0

// =====================================================================
// Counting
`define SCP_BIT_FIRST        3'h0
`define SCP_BIT_LAST         3'h7
`define SCP_BIT_STEP         3'h1
`define SCP_CNT_ONE          2'h0
`define SCP_CNT_STEP         2'h1
`define SCP_ADDR_STEP        5'h01

`endif

// File: shared/scp_pkg.sv
package scp_pkg;

  // =====================================================================
  // Transfer phases
  typedef enum logic [2:0] {
    SCP_IDLE,
    SCP_HEADER,
    SCP_WDATA,
    SCP_RDATA,
    SCP_DONE
  } scp_phase_t;

  // =====================================================================
  // Whole state of the serial port
  typedef struct packed {
    scp_phase_t  phase;
    logic [2:0]  sclk_sync;
    logic [2:0]  sen_sync;
    logic [2:0]  dat_sync;
    logic        sclk_flt;
    logic        sen_flt;
    logic        dat_flt;
    logic [7:0]  hdr;
    logic [7:0]  shreg;
    logic [2:0]  bitcnt;
    logic [1:0]  bytes_left;
    logic [4:0]  addr;
    logic        drive_on;
    logic        out_bit;
    logic        four_wire;
    logic        lsb_first;
    logic        wr_stb;
    logic [4:0]  wr_addr;
    logic [7:0]  wr_data;
  } scp_state_t;

  localparam scp_state_t SCP_STATE_RST = '{
    phase:    SCP_IDLE,
    sen_sync: 3'h7,
    sen_flt:  1'b1,
    default:  '0
  };

endpackage : scp_pkg

// File: design/scp_regfile.sv
`timescale 1ns/10ps
`default_nettype none

module scp_regfile #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  // =====================================================================
  // Storage and registered read port
  typedef struct packed {
    logic [(2**AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rdata;
  } scp_rf_state_t;

  scp_rf_state_t st_r;
  scp_rf_state_t st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = st_r.mem[raddr];
    if (we) begin
      st_nxt.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;

endmodule : scp_regfile

`default_nettype wire

// File: sim/scp_checker.sv
`timescale 1ns/10ps
`default_nettype none

module scp_checker #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
) (
  input wire logic              REF_CLK,
  input wire logic              ARST_N,
  input wire logic              SERIAL_CLK,
  input wire logic              SERIAL_ENABLE_N,
  input wire logic              SERIAL_DATA_OE,
  input wire logic              SERIAL_OUT_PIN_O,
  input wire logic              SERIAL_OUT_PIN_OE,
  input wire logic              FOUR_WIRE,
  input wire logic              LSB_FIRST,
  input wire logic              REG_WR_STROBE,
  input wire logic [ADDR_W-1:0] REG_WR_ADDR,
  input wire logic [DATA_W-1:0] REG_WR_DATA
);
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // ==========
  // Read data steps
  sequence bit_launch;
    $rose(SERIAL_DATA_OE) || $rose(SERIAL_OUT_PIN_OE);
  endsequence
  sequence bit_change;
    (SERIAL_DATA_OE || SERIAL_OUT_PIN_OE) && $changed(SERIAL_OUT_PIN_O);
  endsequence

  // ==========
  // Checks
  idle_release_a: assert property (
    SERIAL_ENABLE_N [*6] |-> !SERIAL_DATA_OE && !SERIAL_OUT_PIN_OE)
    else $error("pin driven while idle");
  three_wire_out_a: assert property (
    !FOUR_WIRE |-> !SERIAL_OUT_PIN_OE)
    else $error("output pin driven in three-wire");
  four_wire_in_a: assert property (
    FOUR_WIRE |-> !SERIAL_DATA_OE)
    else $error("data pin driven in four-wire");
  reset_order_a: assert property (
    $rose(ARST_N) |-> !LSB_FIRST && !FOUR_WIRE)
    else $error("options not cleared by reset");
  strobe_pulse_a: assert property (
    REG_WR_STROBE |=> !REG_WR_STROBE [*7])
    else $error("strobe too long");
  strobe_frame_a: assert property (
    REG_WR_STROBE |-> !$past(SERIAL_ENABLE_N, 4) && !SERIAL_DATA_OE
      && !SERIAL_OUT_PIN_OE)
    else $error("strobe outside write");
  read_launch_a: assert property (
    bit_launch |-> !SERIAL_CLK && !SERIAL_ENABLE_N)
    else $error("read launch off falling clock");
  bit_change_a: assert property (
    bit_change |-> !SERIAL_CLK)
    else $error("read bit changed with clock high");
  opt_update_a: assert property (
    ($changed(FOUR_WIRE) || $changed(LSB_FIRST)) |-> REG_WR_ADDR == '0
      && FOUR_WIRE == REG_WR_DATA[7] && LSB_FIRST == REG_WR_DATA[6])
    else $error("options changed without write");
endmodule : scp_checker

bind scp_serial_port scp_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .SERIAL_CLK(SERIAL_CLK),
  .SERIAL_ENABLE_N(SERIAL_ENABLE_N), .SERIAL_DATA_OE(SERIAL_DATA_OE),
  .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O), .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE),
  .FOUR_WIRE(FOUR_WIRE), .LSB_FIRST(LSB_FIRST),
  .REG_WR_STROBE(REG_WR_STROBE), .REG_WR_ADDR(REG_WR_ADDR),
  .REG_WR_DATA(REG_WR_DATA));

`default_nettype wire

// File: sim/scp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module scp_host_model (
  input  wire logic ref_clk,
  input  wire logic sdio_in,
  input  wire logic sdo_in,
  output var  logic sclk,
  output var  logic sen_n,
  output var  logic sdio_d
);
  initial begin
    sclk = 1'b0;
    sen_n = 1'b1;
    sdio_d = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // ==========
  // One bit: low 250 ns, high 150 ns
  task automatic put_bit(input logic b, input logic rel, input logic fw,
                         output logic got);
    sclk = 1'b0;
    sdio_d = rel ? ~sdio_d : b;
    step(5);
    got = fw ? sdo_in : sdio_in;
    sclk = 1'b1;
    step(3);
  endtask : put_bit

  // ==========
  // Whole transfer
  task automatic xfer(input logic rd, input logic [1:0] c,
                      input logic [4:0] a, input logic l, input logic fw,
                      input logic [31:0] wd, output logic [31:0] rv);
    logic [7:0] hdr;
    logic       got;
    int         i;
    int         j;
    hdr = {rd, c, a};
    rv = '0;
    sen_n = 1'b0;
    step(5);
    for (i = 0; i < 8; i++) begin
      put_bit(hdr[l ? i : 7 - i], 1'b0, fw, got);
    end
    for (i = 0; i < 8 * (c + 1); i++) begin
      j = (i / 8) * 8 + (l ? i % 8 : 7 - i % 8);
      put_bit(wd[j], rd, fw, got);
      rv[j] = got;
    end
    sclk = 1'b0;
    step(5);
    sen_n = 1'b1;
    step(8);
  endtask : xfer
endmodule : scp_host_model

`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        clk, arst_n, sclk, sen_n, sdio_d, d_o, d_oe, p_o, p_oe;
  logic        four_wire, lsb_first, stb;
  logic [4:0]  wadr;
  logic [7:0]  wdat;
  logic [12:0] wq[$];
  int          num_errors = 0;
  int          num_checks = 0;
  wire logic   sdio = d_oe ? d_o : sdio_d;
  wire logic   serial_out_pin = p_oe ? p_o : ~p_o;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  scp_serial_port dut_u (.REF_CLK(clk), .ARST_N(arst_n), .SERIAL_CLK(sclk),
    .SERIAL_ENABLE_N(sen_n), .SERIAL_DATA_I(sdio), .SERIAL_DATA_O(d_o),
    .SERIAL_DATA_OE(d_oe), .SERIAL_OUT_PIN_O(p_o), .SERIAL_OUT_PIN_OE(p_oe),
    .FOUR_WIRE(four_wire), .LSB_FIRST(lsb_first), .REG_WR_STROBE(stb),
    .REG_WR_ADDR(wadr), .REG_WR_DATA(wdat));
  scp_host_model host_u (.ref_clk(clk), .sdio_in(sdio), .sdo_in(serial_out_pin),
    .sclk(sclk), .sen_n(sen_n), .sdio_d(sdio_d));

  // Strobe taken mid-cycle, clear of the edge that launches it
  always @(negedge clk) begin
    if (stb === 1'b1) begin
      wq.push_back({wadr, wdat});
    end
  end

  // ==========
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] c, input logic [4:0] a,
                    input logic l, input logic f, input logic [31:0] d);
    logic [31:0] r;
    logic [4:0]  ea;
    wq.delete();
    host_u.xfer(1'b0, c, a, l, f, d, r);
    chk(16'(wq.size()), 16'(c) + 16'h1);
    for (int k = 0; k <= int'(c) && k < wq.size(); k++) begin
      ea = l ? a + 5'(k) : a - 5'(k);
      chk(16'(wq[k]), 16'({ea, d[8*k+:8]}));
    end
  endtask : wr

  task automatic rdb(input logic [1:0] c, input logic [4:0] a,
                     input logic l, input logic f, input logic [31:0] e);
    logic [31:0] r;
    host_u.xfer(1'b1, c, a, l, f, 32'h0, r);
    for (int k = 0; k <= int'(c); k++) begin
      chk(16'(r[8*k+:8]), 16'(e[8*k+:8]));
    end
  endtask : rdb

  // ==========
  // Scenarios
  task automatic t_defaults;
    chk(16'({four_wire, lsb_first}), 16'h0);
    rdb(2'h0, 5'h00, 1'b0, 1'b0, 32'h0);
    $display("t_defaults end");
  endtask : t_defaults

  task automatic t_msb;
    wr(2'h1, 5'h05, 1'b0, 1'b0, 32'h0000_3CA5);
    rdb(2'h1, 5'h05, 1'b0, 1'b0, 32'h0000_3CA5);
    wr(2'h1, 5'h00, 1'b0, 1'b0, 32'h0000_5A00);
    rdb(2'h0, 5'h1F, 1'b0, 1'b0, 32'h0000_005A);
    $display("t_msb end");
  endtask : t_msb

  task automatic t_counts;
    for (int c = 0; c < 4; c++) begin
      wr(2'(c), 5'h10, 1'b0, 1'b0, 32'hC3B2_A190 ^ 32'(c));
    end
    rdb(2'h3, 5'h10, 1'b0, 1'b0, 32'hC3B2_A193);
    $display("t_counts end");
  endtask : t_counts

  task automatic t_lsb;
    wr(2'h0, 5'h00, 1'b0, 1'b0, 32'h40);
    chk(16'(lsb_first), 16'h1);
    wr(2'h2, 5'h14, 1'b1, 1'b0, 32'h00E7_1D6B);
    rdb(2'h2, 5'h14, 1'b1, 1'b0, 32'h00E7_1D6B);
    wr(2'h0, 5'h00, 1'b1, 1'b0, 32'h0);
    chk(16'(lsb_first), 16'h0);
    $display("t_lsb end");
  endtask : t_lsb

  task automatic t_four;
    wr(2'h0, 5'h00, 1'b0, 1'b0, 32'h80);
    chk(16'(four_wire), 16'h1);
    rdb(2'h1, 5'h05, 1'b0, 1'b1, 32'h0000_3CA5);
    rdb(2'h0, 5'h00, 1'b0, 1'b1, 32'h80);
    wr(2'h0, 5'h00, 1'b0, 1'b1, 32'h0);
    chk(16'(four_wire), 16'h0);
    $display("t_four end");
  endtask : t_four

  // ==========
  // Run control
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("unexpected %0t: timeout", $time);
    complete_run();
  end

  initial begin
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    t_defaults();
    t_msb();
    t_counts();
    t_lsb();
    t_four();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
